//--- hdl/dsws_pkg.sv
/*
 * constants, register map and state codes of the deep sleep wake sequencer.
 * assumes a single 10 MHz clock, which also serves as the standby time base.
 */
// Operation
// R1: bit 7 removes suspend pin pull-up
// R2: bit 6 resume-reset source, 1 reserved
// R3: option 0: hold switch until S3 high
// R4: option 1: hold until resume and suspend high
// R5: option only when both enables set
// R6: well enable lets suspend gate resume reset
// R7: bit 0 enables deep soft-off on S5
// R8: wake delay is field times 16 ms
// R9: wake pulse is field times 32 ms
// R10: wake delay resets to 20h on resume reset
// R11: pulse width resets to 04h on resume reset
// R12: entry unit bit: seconds or minutes
// R13: wait entry count after leaving S0
// R14: prescaled time bases, counters restart when withdrawn

package dsws_pkg;

    // ------------------------------------------------------------------
    // time bases
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;        // aclk period
    localparam int NS_PER_MS     = 1000000;    // unit conversion
    localparam int BASE16_MS     = 16;         // wake delay step
    localparam int BASE32_MS     = 32;         // wake pulse step
    localparam int SECOND_MS     = 1000;       // entry delay unit, seconds
    localparam int MINUTE_S      = 60;         // seconds in a minute
    localparam int TICK16_CYC    = BASE16_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int TICK32_CYC    = BASE32_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int SECOND_CYC    = SECOND_MS * NS_PER_MS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register map (index = printed offset, byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 12;
    localparam logic [9:0] IDX_CFG     = 10'h030;   // deep_sleep_config
    localparam logic [9:0] IDX_DLY     = 10'h0e0;   // wake_pulse_delay
    localparam logic [9:0] IDX_PW      = 10'h0e1;   // wake_pulse_width
    localparam logic [9:0] IDX_ENTRY   = 10'h0e2;   // sleep_entry_delay
    localparam logic [9:0] IDX_STATUS  = 10'h0e3;   // sequencer status, read only
    localparam logic [11:0] ADDR_CFG    = {IDX_CFG, 2'b00};
    localparam logic [11:0] ADDR_DLY    = {IDX_DLY, 2'b00};
    localparam logic [11:0] ADDR_PW     = {IDX_PW, 2'b00};
    localparam logic [11:0] ADDR_ENTRY  = {IDX_ENTRY, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // ------------------------------------------------------------------
    // fields, reset values and writable masks
    // ------------------------------------------------------------------
    localparam int CFG_PULLUP_DIS_BIT = 7;
    localparam int CFG_RSM_SRC_BIT    = 6;
    localparam int CFG_WAKE_OPT_BIT   = 4;
    localparam int CFG_WELL_EN_BIT    = 3;
    localparam int CFG_DS_EN_BIT      = 0;
    localparam int ENTRY_UNIT_BIT     = 7;
    localparam int DLY_W              = 6;
    localparam int PW_W               = 4;
    localparam int ENTRY_W            = 7;
    localparam logic [7:0] CFG_RST    = 8'h20;
    localparam logic [7:0] DLY_RST    = 8'h20;
    localparam logic [7:0] PW_RST     = 8'h04;
    localparam logic [7:0] ENTRY_RST  = 8'h05;
    localparam logic [7:0] CFG_WMASK  = 8'hdd;
    localparam logic [7:0] DLY_WMASK  = 8'h3f;
    localparam logic [7:0] PW_WMASK   = 8'h0f;
    localparam logic [7:0] ENTRY_WMASK = 8'hff;

    // ------------------------------------------------------------------
    // bus answers and pin synchroniser layout
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int PIN_S5   = 0;                 // soft_off_sleep_n
    localparam int PIN_S3   = 1;                 // suspend_ram_sleep_n
    localparam int PIN_SUS  = 2;                 // suspend_sleep_n
    localparam int PIN_RSM  = 3;                 // resume_reset_in_n
    localparam int PIN_STB  = 4;                 // standby_rail_present
    localparam int PIN_WAKE = 5;                 // wake_request
    localparam int PIN_N    = 6;
    localparam logic [5:0] SYNC_RST = 6'h0f;     // inactive pin levels

    // sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_RUN        = 6'h01,
        ST_ENTRY_WAIT = 6'h02,
        ST_DEEP       = 6'h04,
        ST_WAKE_DELAY = 6'h08,
        ST_WAKE_PULSE = 6'h10,
        ST_WAKE_HOLD  = 6'h20
    } dsws_state_type;

endpackage

//--- hdl/dsws_tick_div.sv
/*
 * prescaler: emits one tick every PERIOD steps.
 * assumes restart is a same-clock level; step is a same-clock strobe.
 */
`timescale 1ns/1ns
`default_nettype none

module dsws_tick_div #(
    parameter int PERIOD = 16,
    parameter int W      = 32
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic restart,
    input  wire logic step,
    // output
    output var  logic tick
);
    logic [W-1:0] cnt_q;    // steps seen since last tick
    logic [W-1:0] cnt_d;    // next count
    wire          wrap = step && (cnt_q == W'(PERIOD - 1));

    // ------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------
    // restart wins, so a withdrawn trigger never leaves a partial count
    assign cnt_d = restart ? '0 : (wrap ? '0 : (step ? cnt_q + W'(1) : cnt_q));
    assign tick  = wrap && !restart;

    // count register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

`default_nettype wire

//--- hdl/dsws_sequencer.sv
/*
 * deep sleep wake sequencer: register file on AXI4-Lite, deep soft-off
 * entry timing, wake pulse on the power switch output, resume-reset gating.
 * assumes chipset pins are asynchronous; aclk is the standby clock.
 */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module dsws_sequencer #(
    parameter int TICK16_CYC = dsws_pkg::TICK16_CYC,
    parameter int TICK32_CYC = dsws_pkg::TICK32_CYC,
    parameter int SECOND_CYC = dsws_pkg::SECOND_CYC
) (
    // clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // axi4-lite write address
    input  wire logic                        awvalid,
    output var  logic                        awready,
    input  wire logic [dsws_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                  awprot,
    // axi4-lite write data
    input  wire logic                        wvalid,
    output var  logic                        wready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    // axi4-lite write response
    output var  logic                        bvalid,
    input  wire logic                        bready,
    output var  logic [1:0]                  bresp,
    // axi4-lite read address
    input  wire logic                        arvalid,
    output var  logic                        arready,
    input  wire logic [dsws_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                  arprot,
    // axi4-lite read data
    output var  logic                        rvalid,
    input  wire logic                        rready,
    output var  logic [31:0]                 rdata,
    output var  logic [1:0]                  rresp,
    // chipset sleep and reset pins
    input  wire logic                        soft_off_sleep_n,
    input  wire logic                        suspend_ram_sleep_n,
    input  wire logic                        suspend_sleep_n,
    input  wire logic                        resume_reset_in_n,
    input  wire logic                        standby_rail_present,
    input  wire logic                        wake_request,
    // outputs to the platform
    output var  logic                        power_switch_out_n,
    output var  logic                        resume_reset_n,
    output var  logic                        suspend_pin_pullup_disable,
    output var  logic                        deep_soft_off
);
    import dsws_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [PIN_N-1:0] sync1_q;            // first synchroniser stage
    logic [PIN_N-1:0] pin_q;              // synchronised pins
    logic [7:0]       cfg_q;              // deep_sleep_config
    logic [7:0]       dly_q;              // wake_pulse_delay
    logic [7:0]       pw_q;               // wake_pulse_width
    logic [7:0]       entry_q;            // sleep_entry_delay
    logic             bvalid_q;           // write answer pending
    logic [1:0]       bresp_q;            // write answer code
    logic             rvalid_q;           // read answer pending
    logic [31:0]      rdata_q;            // read answer data
    logic [1:0]       rresp_q;            // read answer code
    dsws_state_type   state_q;            // sequencer state
    dsws_state_type   state_d;            // next sequencer state
    logic [ENTRY_W-1:0] unit_cnt_q;       // elapsed time units
    logic             psw_n_q;            // power switch output
    logic             rsm_out_q;          // resume reset output
    logic             tick16;             // 16 ms base
    logic             tick32;             // 32 ms base
    logic             tick_sec;           // one second base
    logic             tick_min;           // one minute base

    // synchronised pin levels
    wire s5_n    = pin_q[PIN_S5];
    wire s3_n    = pin_q[PIN_S3];
    wire sus_n   = pin_q[PIN_SUS];
    wire rsm_n   = pin_q[PIN_RSM];
    wire stb     = pin_q[PIN_STB];
    wire wake    = pin_q[PIN_WAKE];

    // configuration fields
    wire ds_en   = cfg_q[CFG_DS_EN_BIT];
    wire well_en = cfg_q[CFG_WELL_EN_BIT];
    // option honoured only with both enables set (see R5)
    wire opt_eff = cfg_q[CFG_WAKE_OPT_BIT] && well_en && ds_en;
    wire [DLY_W-1:0]   dly_f   = dly_q[DLY_W-1:0];
    wire [PW_W-1:0]    pw_f    = pw_q[PW_W-1:0];
    wire [ENTRY_W-1:0] entry_f = entry_q[ENTRY_W-1:0];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire wr_fire   = awvalid && wvalid && !bvalid_q;
    wire rd_fire   = arvalid && !rvalid_q;
    wire wr_cfg    = wr_fire && wstrb[0] && (awaddr == ADDR_CFG);
    wire wr_dly    = wr_fire && wstrb[0] && (awaddr == ADDR_DLY);
    wire wr_pw     = wr_fire && wstrb[0] && (awaddr == ADDR_PW);
    wire wr_entry  = wr_fire && wstrb[0] && (awaddr == ADDR_ENTRY);
    wire wr_hit    = (awaddr == ADDR_CFG) || (awaddr == ADDR_DLY) ||
                     (awaddr == ADDR_PW) || (awaddr == ADDR_ENTRY);
    wire rd_hit    = (araddr == ADDR_CFG) || (araddr == ADDR_DLY) ||
                     (araddr == ADDR_PW) || (araddr == ADDR_ENTRY) ||
                     (araddr == ADDR_STATUS);
    wire [7:0] wd8 = wdata[7:0];
    wire [7:0] status_v = {2'b00, state_q};
    wire [7:0] rd_mux = (araddr == ADDR_CFG)    ? cfg_q   :
                        (araddr == ADDR_DLY)    ? dly_q   :
                        (araddr == ADDR_PW)     ? pw_q    :
                        (araddr == ADDR_ENTRY)  ? entry_q :
                        (araddr == ADDR_STATUS) ? status_v : 8'h00;

    assign awready = wr_fire;
    assign wready  = wr_fire;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // write answer: one per taken address and data pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read answer: data captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h0, rd_mux};
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // battery-well registers: cleared only by the block reset;
    // source select value 1 is reserved and behaves as 0 (see R2)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q   <= CFG_RST;
            entry_q <= ENTRY_RST;
        end else begin
            if (wr_cfg) cfg_q <= (cfg_q & ~CFG_WMASK) | (wd8 & CFG_WMASK);
            if (wr_entry) entry_q <= (entry_q & ~ENTRY_WMASK) | (wd8 & ENTRY_WMASK);
        end
    end

    // standby-well registers: also cleared by resume reset (see R10, R11)
    always_ff @(posedge aclk) begin
        if (!aresetn || !rsm_n) begin
            dly_q <= DLY_RST;
            pw_q  <= PW_RST;
        end else begin
            if (wr_dly) dly_q <= (dly_q & ~DLY_WMASK) | (wd8 & DLY_WMASK);
            if (wr_pw) pw_q <= (pw_q & ~PW_WMASK) | (wd8 & PW_WMASK);
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two stages; only pin_q is read by logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= SYNC_RST;
            pin_q   <= SYNC_RST;
        end else begin
            sync1_q <= {wake_request, standby_rail_present, resume_reset_in_n,
                        suspend_sleep_n, suspend_ram_sleep_n, soft_off_sleep_n};
            pin_q   <= sync1_q;
        end
    end

    // ------------------------------------------------------------------
    // time bases
    // ------------------------------------------------------------------
    // prescalers restart with every state change (see R14)
    wire restart = (state_d != state_q) || ((state_q == ST_WAKE_DELAY) && !stb);

    dsws_tick_div #(.PERIOD(TICK16_CYC), .W(32)) u_tick16 (
        .aclk(aclk), .aresetn(aresetn), .restart(restart), .step(1'b1), .tick(tick16));
    dsws_tick_div #(.PERIOD(TICK32_CYC), .W(32)) u_tick32 (
        .aclk(aclk), .aresetn(aresetn), .restart(restart), .step(1'b1), .tick(tick32));
    dsws_tick_div #(.PERIOD(SECOND_CYC), .W(32)) u_tick_sec (
        .aclk(aclk), .aresetn(aresetn), .restart(restart), .step(1'b1), .tick(tick_sec));
    dsws_tick_div #(.PERIOD(MINUTE_S), .W(8)) u_tick_min (
        .aclk(aclk), .aresetn(aresetn), .restart(restart), .step(tick_sec),
        .tick(tick_min));

    // unit in force: seconds or minutes for entry (see R12), fixed bases for wake
    wire unit_tick = (state_q == ST_ENTRY_WAIT) ? (entry_q[ENTRY_UNIT_BIT] ? tick_min
                                                                           : tick_sec) :
                     (state_q == ST_WAKE_DELAY) ? tick16 :
                     (state_q == ST_WAKE_PULSE) ? tick32 : 1'b0;

    // elapsed units in the current state
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            unit_cnt_q <= '0;
        end else if (unit_tick) begin
            unit_cnt_q <= unit_cnt_q + ENTRY_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    wire entry_trig = ds_en && !s5_n && !s3_n;                   // see R7
    wire entry_done = unit_cnt_q >= entry_f;                     // see R13
    wire dly_done   = stb && (unit_cnt_q >= ENTRY_W'(dly_f));    // see R8
    wire pw_done    = unit_cnt_q >= ENTRY_W'(pw_f);              // see R9
    // release of the held switch output (see R3, R4)
    wire release_ok = opt_eff ? (rsm_n && sus_n) : s3_n;

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (entry_trig) state_d = ST_ENTRY_WAIT;
            end
            ST_ENTRY_WAIT: begin
                // withdrawn trigger aborts the wait (see R14)
                if (!entry_trig) state_d = ST_RUN;
                else if (entry_done) state_d = ST_DEEP;
            end
            ST_DEEP: begin
                if (wake) state_d = ST_WAKE_DELAY;
            end
            ST_WAKE_DELAY: begin
                if (dly_done) state_d = ST_WAKE_PULSE;
            end
            ST_WAKE_PULSE: begin
                if (pw_done) state_d = ST_WAKE_HOLD;
            end
            ST_WAKE_HOLD: begin
                if (release_ok) state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // state and pin outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= ST_RUN;
            psw_n_q   <= 1'b1;
            rsm_out_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            // low through pulse and hold (see R9, R3, R4)
            psw_n_q   <= !((state_d == ST_WAKE_PULSE) || (state_d == ST_WAKE_HOLD));
            // suspend sleep gates resume reset when the well is used (see R6)
            rsm_out_q <= rsm_n && (sus_n || !well_en);
        end
    end

    assign power_switch_out_n         = psw_n_q;
    assign resume_reset_n             = rsm_out_q;
    assign suspend_pin_pullup_disable = cfg_q[CFG_PULLUP_DIS_BIT];   // see R1
    assign deep_soft_off              = (state_q == ST_DEEP);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pullup_bit: assert property (suspend_pin_pullup_disable == cfg_q[7]) // see R1
        else $error("pull-up control does not follow config bit 7");
    a_hold_s3: assert property (state_q == ST_WAKE_HOLD && !opt_eff && s3_n // see R3
        |=> state_q == ST_RUN && power_switch_out_n)
        else $error("hold not released by S3 high");
    a_hold_both: assert property (state_q == ST_WAKE_HOLD && opt_eff && !(rsm_n && sus_n) // see R4
        |=> !power_switch_out_n)
        else $error("hold released before resume and suspend high");
    a_opt_gate: assert property (!(well_en && ds_en) && state_q == ST_WAKE_HOLD // see R5
        && !s3_n |=> state_q == ST_WAKE_HOLD)
        else $error("release option acted without both enables");
    a_rsm_gated: assert property (well_en && !sus_n ##1 well_en |-> !resume_reset_n) // see R6
        else $error("resume reset not gated by suspend sleep");
    a_no_entry: assert property (state_q == ST_RUN && !ds_en // see R7
        |=> state_q != ST_ENTRY_WAIT)
        else $error("deep soft-off entry while disabled");
    a_wake_high: assert property (state_q == ST_WAKE_DELAY |-> power_switch_out_n) // see R8
        else $error("switch output low during wake delay");
    a_pulse_low: assert property (state_q == ST_WAKE_PULSE |-> !power_switch_out_n) // see R9
        else $error("switch output high during wake pulse");
    a_wake_rst: assert property (!rsm_n |=> dly_q == DLY_RST && pw_q == PW_RST) // see R10
        else $error("wake timing fields not reset by resume reset");
    a_entry_count: assert property (state_q == ST_ENTRY_WAIT && $rose(state_q == ST_DEEP) // see R13
        or (state_q == ST_ENTRY_WAIT && state_d == ST_DEEP) |-> unit_cnt_q >= entry_f)
        else $error("deep sleep entered before entry delay");
    a_unit_sel: assert property (state_q == ST_ENTRY_WAIT && entry_q[7] && tick_sec // see R12
        && !tick_min && !restart |=> $stable(unit_cnt_q))
        else $error("entry counted seconds in minute mode");

    c_deep: cover property (state_q == ST_ENTRY_WAIT ##1 state_q == ST_DEEP);
    c_pulse: cover property (state_q == ST_WAKE_PULSE ##1 state_q == ST_WAKE_HOLD);
    c_release: cover property (state_q == ST_WAKE_HOLD ##1 state_q == ST_RUN);
    c_write: cover property (wr_fire && wr_hit);

endmodule

`default_nettype wire

//--- testbench/dsws_chipset.sv
/* chipset model: drives the sleep and reset pins and raises wake events.
 * assumes ctl and wake_go change at rising clock edges. */
`timescale 1ns/1ns
`default_nettype none
module dsws_chipset (
    // clock, control from the bench and the sequencer switch output
    input  wire logic       aclk,
    input  wire logic [2:0] ctl,
    input  wire logic       wake_go,
    input  wire logic       rsm_ctl,
    input  wire logic       power_switch_out_n,
    // chipset pins
    output wire logic       soft_off_sleep_n,
    output wire logic       suspend_ram_sleep_n,
    output wire logic       suspend_sleep_n,
    output wire logic       resume_reset_in_n,
    output wire logic       standby_rail_present,
    output wire logic       wake_request
);
    logic wk_q = 1'b0;                       // wake event latch
    assign soft_off_sleep_n     = ctl[0];
    assign suspend_ram_sleep_n  = ctl[1];
    assign suspend_sleep_n      = ctl[2];
    assign resume_reset_in_n    = rsm_ctl;   // resume reset from the bench
    assign standby_rail_present = 1'b1;      // standby rail stays up
    assign wake_request         = wk_q;
    // wake event holds until the switch output answers
    always @(posedge aclk) begin
        if (wake_go) wk_q <= 1'b1;
        else if (!power_switch_out_n) wk_q <= 1'b0;
    end
endmodule
`default_nettype wire

//--- testbench/tb_deep_sleep_wake_sequencer.sv
/* bench: register file over axi4-lite, entry delay, wake pulse and hold.
 * assumes shortened time bases: 16, 32 and 20 clock cycles. */
`timescale 1ns/1ns
`default_nettype none
module tb_deep_sleep_wake_sequencer;
    import dsws_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, wake_go = 0, rsm_ctl = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h846d0406;
    logic [2:0]  ctl = 3'h7;
    logic [3:0]  wstrb = 4'h1;
    logic [1:0]  bresp, rresp;
    wire awready, wready, bvalid, arready, rvalid, soft_off_sleep_n, suspend_ram_sleep_n;
    wire suspend_sleep_n, resume_reset_in_n, standby_rail_present, wake_request;
    wire power_switch_out_n, resume_reset_n, suspend_pin_pullup_disable, deep_soft_off;
    int n_mismatch = 0, n_tests = 0, cyc = 0, m[int], t, dly, opt;
    dsws_sequencer #(.TICK16_CYC(16), .TICK32_CYC(32), .SECOND_CYC(20)) u_dut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .soft_off_sleep_n,
        .suspend_ram_sleep_n, .suspend_sleep_n, .resume_reset_in_n, .standby_rail_present,
        .wake_request, .power_switch_out_n, .resume_reset_n, .suspend_pin_pullup_disable,
        .deep_soft_off);
    dsws_chipset u_chip (.aclk, .ctl, .wake_go, .power_switch_out_n, .soft_off_sleep_n,
        .suspend_ram_sleep_n, .suspend_sleep_n, .resume_reset_in_n, .standby_rail_present,
        .wake_request, .rsm_ctl);
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // write one register and update the model on success
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic [7:0] wm;
        wm = a == ADDR_CFG ? CFG_WMASK : a == ADDR_DLY ? DLY_WMASK : a == ADDR_PW ? PW_WMASK
            : ENTRY_WMASK;
        @(posedge aclk);
        {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, 24'h0, d};
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk);
        {awvalid, wvalid} <= 2'h0;
        while (bvalid !== 1'b1) @(negedge aclk);
        chk(bresp, r);
        @(posedge aclk);
        bready <= 1'b0;
        if (r == RESP_OKAY && wstrb[0]) m[a] = (m[a] & ~wm) | (d & wm);
    endtask
    // read one register; data compared only on an okay answer
    task automatic rc(input logic [11:0] a, input logic [1:0] r, input logic [7:0] d);
        @(posedge aclk);
        {arvalid, rready, araddr} <= {2'h3, a};
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(negedge aclk);
        chk({rresp, r == RESP_OKAY ? rdata : 32'h0}, {r, 24'h0, d});
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // cut a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test;
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        m[ADDR_CFG] = CFG_RST;
        m[ADDR_DLY] = DLY_RST;
        m[ADDR_PW] = PW_RST;
        m[ADDR_ENTRY] = ENTRY_RST;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (m[k]) rc(k, RESP_OKAY, m[k]);
        rc(12'h004, RESP_SLVERR, 8'h00);
        wr(12'h008, 8'h55, RESP_SLVERR);
        foreach (m[k]) begin
            seed = xs(seed);
            wstrb <= {seed[11:9], k != ADDR_PW};
            wr(k, seed[7:0], RESP_OKAY);
            rc(k, RESP_OKAY, m[k]);
        end
        wstrb <= 4'h1;
        wr(ADDR_CFG, 8'h80, RESP_OKAY);
        chk(suspend_pin_pullup_disable, 1);
        wr(ADDR_CFG, 8'h00, RESP_OKAY);
        ctl <= 3'h0;
        repeat (60) @(negedge aclk);
        chk(deep_soft_off, 0);
        for (opt = 0; opt < 2; opt++) begin
            seed = xs(seed);
            dly = 1 + seed[1:0];
            @(posedge aclk) {ctl, wake_go} <= 4'he;
            wr(ADDR_DLY, dly[7:0], RESP_OKAY);
            wr(ADDR_PW, 8'h01, RESP_OKAY);
            wr(ADDR_ENTRY, opt ? 8'h81 : 8'h01, RESP_OKAY);
            wr(ADDR_CFG, opt ? 8'h19 : 8'h01, RESP_OKAY); // source bit kept 0
            ctl <= 3'h0;
            t = 0;
            while (deep_soft_off !== 1'b1) begin
                @(negedge aclk);
                t++;
            end
            chk(t >= (opt ? 1200 : 20) && t <= (opt ? 1210 : 30), 1);
            @(posedge aclk) wake_go <= 1'b1;
            for (t = 0; power_switch_out_n !== 1'b0; t++) @(negedge aclk);
            chk(t >= dly * 16 && t <= dly * 16 + 12, 1);
            @(posedge aclk) wake_go <= 1'b0;
            repeat (40) @(negedge aclk);
            chk(power_switch_out_n, 0);
            chk(resume_reset_n, opt ? 0 : 1);
            @(posedge aclk) ctl <= 3'h3;
            repeat (10) @(negedge aclk);
            chk(power_switch_out_n, opt ? 0 : 1);
            @(posedge aclk) ctl <= 3'h7;
            repeat (8) @(negedge aclk);
            chk(power_switch_out_n, 1);
        end
        // resume reset restores the wake timing fields
        @(posedge aclk) rsm_ctl <= 1'b0;
        repeat (5) @(posedge aclk);
        chk(resume_reset_n, 0);
        rsm_ctl <= 1'b1;
        m[ADDR_DLY] = DLY_RST;
        m[ADDR_PW] = PW_RST;
        foreach (m[k]) rc(k, RESP_OKAY, m[k]);
        stop_test;
    end
endmodule
`default_nettype wire
